// File: verilog/asmc_sleep_ctrl.sv
// Sleep-mode controller of a delta-sigma converter's operating-mode logic.
// Summary of operation
// - Writing 110 to the operation mode field puts the device to sleep.
// - Sleep lasts until a different mode code is written and nothing else ends it.
// - Sleep powers down analog and most digital logic; bias and reference follow their own bits.
// - With chip select in use, taking it low wakes the serial port for a normal transfer.
// - In master mode, chip select tied low, a data fall after two high periods wakes the port.
// - In slave mode, chip select tied low, an ordinary instruction byte restores the link.
// - A non-sleep code runs a short power-up and two conversions, after which the mode applies.
// - After sleep, data-ready stays high through the first and second conversion cycles.
// - Bias and reference enables are not restored on wake; the host must set them again.
// - Codes 000 to 101 are normal, self-cal, offset, full-scale, pseudo and background.
`timescale 1ns/1ps
`include "asmc_defines.svh"
module asmc_sleep_ctrl
  import asmc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       mode_write,
  input  wire logic [2:0] operation_mode_field,
  input  wire logic       bias_enable_in,
  input  wire logic       reference_output_enable_in,
  input  wire logic       conv_cycle_end,
  input  wire logic       conv_data_ready,
  input  wire logic       cs_used,
  input  wire logic       master_mode,
  input  wire logic       chip_select_n,
  input  wire logic       sdio_in,
  input  wire logic       instr_strobe,
  output logic [2:0]      active_mode,
  output logic            sleeping,
  output logic            analog_power_en,
  output logic            digital_power_en,
  output logic            bias_enable,
  output logic            reference_output_enable,
  output logic            serial_awake,
  output logic            data_ready_n,
  output logic            mode_normal,
  output logic            mode_self_cal,
  output logic            mode_sys_offset,
  output logic            mode_sys_full_scale,
  output logic            mode_pseudo_cal,
  output logic            mode_background
);
  // ==========================================================
  // Reset release
  logic       rst_meta;
  logic       rst_n;
  // Assertion acts at once; release passes two flops so no flop leaves reset on a late edge.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Mode decode
  // Exact code compare, shared by the write decode and the mode strobes.
  function automatic logic is_code(input logic [2:0] m, input logic [2:0] c);
    is_code = (m == c);
  endfunction

  asmc_state_t state;
  asmc_state_t next_state;
  logic [2:0]  pending_mode;
  logic [7:0]  pu_count;
  logic        wake;
  logic        write_sleep;
  logic        write_other;
  logic        pu_done;

  // Write decode and end of power-up.
  // The counter starts at zero, so the last power-up cycle is one short of the length.
  assign write_sleep = mode_write && is_code(operation_mode_field, `ASMC_MODE_SLEEP);
  assign write_other = mode_write && !is_code(operation_mode_field, `ASMC_MODE_SLEEP);
  assign pu_done     = (pu_count == `ASMC_POWERUP_CYCLES - 8'h1);

  // Wake detection for the serial port while asleep.
  asmc_wake_detect u_wake (
    .clock         (clock),
    .rst_n         (rst_n),
    .sleeping      (state == ASMC_SLEEP),
    .cs_used       (cs_used),
    .master_mode   (master_mode),
    .chip_select_n (chip_select_n),
    .sdio_in       (sdio_in),
    .instr_strobe  (instr_strobe),
    .wake          (wake)
  );

  // ==========================================================
  // State sequencing
  // Only a mode write leaves sleep; serial wake merely reopens the port.
  always_comb begin
    next_state = state;
    case (state)
      ASMC_RUN: begin
        if (write_sleep) begin
          next_state = ASMC_SLEEP;
        end
      end
      ASMC_SLEEP: begin
        if (write_other) begin
          next_state = ASMC_POWERUP;
        end
      end
      ASMC_POWERUP: begin
        if (pu_done) begin
          next_state = ASMC_CONV1;
        end
      end
      ASMC_CONV1: begin
        if (conv_cycle_end) begin
          next_state = ASMC_CONV2;
        end
      end
      ASMC_CONV2: begin
        if (conv_cycle_end && is_code(pending_mode, `ASMC_MODE_SLEEP)) begin
          next_state = ASMC_SLEEP;
        end else if (conv_cycle_end) begin
          next_state = ASMC_RUN;
        end
      end
      default: begin
        next_state = ASMC_RUN;
      end
    endcase
  end

  // The counter clears outside power-up so that every wake gets the full sequence.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ASMC_RUN;
      pu_count <= 8'h0;
    end else begin
      state <= next_state;
      pu_count <= (state == ASMC_POWERUP) ? pu_count + 8'h1 : 8'h0;
    end
  end

  // A code written in run applies at once; otherwise it is held back until a wake conversion ends.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending_mode <= `ASMC_MODE_RESET;
      active_mode  <= `ASMC_MODE_RESET;
    end else begin
      if (mode_write) begin
        pending_mode <= operation_mode_field;
      end
      if (state == ASMC_RUN && write_sleep) begin
        active_mode <= `ASMC_MODE_SLEEP;
      end else if (state == ASMC_RUN && mode_write) begin
        active_mode <= operation_mode_field;
      end else if ((state == ASMC_CONV1 || state == ASMC_CONV2) && conv_cycle_end) begin
        active_mode <= pending_mode;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  logic [2:0] m;
  logic       run_q;
  // Decode from the mode in force; strobes stay low outside the run state.
  assign m     = active_mode;
  assign run_q = (next_state == ASMC_RUN);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleeping                <= 1'b0;
      analog_power_en         <= 1'b1;
      digital_power_en        <= 1'b1;
      bias_enable             <= 1'b0;
      reference_output_enable <= 1'b1;
      serial_awake            <= 1'b1;
      data_ready_n            <= 1'b1;
    end else begin
      sleeping         <= (next_state == ASMC_SLEEP);
      analog_power_en  <= (next_state != ASMC_SLEEP);
      digital_power_en <= (next_state != ASMC_SLEEP);
      // Enables track their own bits only, so wake never restores them.
      bias_enable             <= bias_enable_in;
      reference_output_enable <= reference_output_enable_in;
      // The port closes on sleep entry and reopens on any wake cause.
      if (next_state != ASMC_SLEEP) begin
        serial_awake <= 1'b1;
      end else if (state != ASMC_SLEEP) begin
        serial_awake <= 1'b0;
      end else if (wake) begin
        serial_awake <= 1'b1;
      end
      // Data-ready forced high across the two wake conversions.
      data_ready_n <= run_q && (state == ASMC_RUN) ? !conv_data_ready : 1'b1;
    end
  end

  // Mode strobes for the calibration sequencer.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_normal         <= 1'b0;
      mode_self_cal       <= 1'b0;
      mode_sys_offset     <= 1'b0;
      mode_sys_full_scale <= 1'b0;
      mode_pseudo_cal     <= 1'b0;
      mode_background     <= 1'b0;
    end else begin
      mode_normal         <= run_q && is_code(m, `ASMC_MODE_NORMAL);
      mode_self_cal       <= run_q && is_code(m, `ASMC_MODE_SELF_CAL);
      mode_sys_offset     <= run_q && is_code(m, `ASMC_MODE_SYS_OFS);
      mode_sys_full_scale <= run_q && is_code(m, `ASMC_MODE_SYS_FS);
      mode_pseudo_cal     <= run_q && is_code(m, `ASMC_MODE_PSEUDO);
      mode_background     <= run_q && is_code(m, `ASMC_MODE_BACKGROUND);
    end
  end
endmodule

// File: verilog/asmc_defines.svh
// Constants for the converter sleep-mode controller.
`ifndef ASMC_DEFINES_SVH
`define ASMC_DEFINES_SVH
// Operation mode field codes.
`define ASMC_MODE_NORMAL     3'h0
`define ASMC_MODE_SELF_CAL   3'h1
`define ASMC_MODE_SYS_OFS    3'h2
`define ASMC_MODE_SYS_FS     3'h3
`define ASMC_MODE_PSEUDO     3'h4
`define ASMC_MODE_BACKGROUND 3'h5
`define ASMC_MODE_SLEEP      3'h6
// Reset value of the operation mode field.
`define ASMC_MODE_RESET      3'h0
// Least high time of the data line before a wake edge, in crystal periods.
`define ASMC_WAKE_HIGH_PERIODS 2
// Power-up sequence length in clock cycles.
`define ASMC_POWERUP_CYCLES  8'h10
// Conversion cycles with data-ready held high after wake.
`define ASMC_WAKE_HOLD_CONV  2'h2
`endif

// File: verilog/asmc_pkg.sv
// Types for the converter sleep-mode controller.
package asmc_pkg;
  typedef enum logic [4:0] {
    ASMC_RUN     = 5'b00001,
    ASMC_SLEEP   = 5'b00010,
    ASMC_POWERUP = 5'b00100,
    ASMC_CONV1   = 5'b01000,
    ASMC_CONV2   = 5'b10000
  } asmc_state_t;
endpackage

// File: verilog/asmc_wake_detect.sv
// Serial-port wake detector used while the converter sleeps.
`timescale 1ns/1ps
`include "asmc_defines.svh"
module asmc_wake_detect
  import asmc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic sleeping,
  input  wire logic cs_used,
  input  wire logic master_mode,
  input  wire logic chip_select_n,
  input  wire logic sdio_in,
  input  wire logic instr_strobe,
  output logic      wake
);
  logic [1:0] high_count;
  logic       armed;
  logic       sdio_prev;
  logic       cs_wake;
  logic       edge_wake;
  logic       slave_wake;

  // Wake causes, one for each way the port may be used.
  assign cs_wake    = cs_used && !chip_select_n;
  assign edge_wake  = !cs_used && master_mode && armed && sdio_prev && !sdio_in;
  assign slave_wake = !cs_used && !master_mode && instr_strobe;

  // Count high time of the data line; an edge only counts after two high periods.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_count <= 2'h0;
      armed      <= 1'b0;
      sdio_prev  <= 1'b0;
      wake       <= 1'b0;
    end else begin
      sdio_prev <= sdio_in;
      if (!sleeping || !sdio_in) begin
        high_count <= 2'h0;
      end else if (high_count != 2'(`ASMC_WAKE_HIGH_PERIODS)) begin
        high_count <= high_count + 2'h1;
      end
      armed <= sleeping && sdio_in && (high_count == 2'(`ASMC_WAKE_HIGH_PERIODS) - 2'h1
                                       || high_count == 2'(`ASMC_WAKE_HIGH_PERIODS));
      wake  <= sleeping && (cs_wake || edge_wake || slave_wake);
    end
  end
endmodule

// File: verification/asmc_sleep_ctrl_asserts.sv
// Port assertions for the converter sleep-mode controller.
`timescale 1ns/1ps
module asmc_sleep_ctrl_asserts (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       mode_write,
  input wire logic       bias_enable_in,
  input wire logic       reference_output_enable_in,
  input wire logic       conv_cycle_end,
  input wire logic       cs_used,
  input wire logic       master_mode,
  input wire logic       chip_select_n,
  input wire logic       sdio_in,
  input wire logic       instr_strobe,
  input wire logic       sleeping,
  input wire logic       analog_power_en,
  input wire logic       digital_power_en,
  input wire logic       bias_enable,
  input wire logic       reference_output_enable,
  input wire logic       serial_awake,
  input wire logic       data_ready_n,
  input wire logic       mode_normal,
  input wire logic       mode_self_cal,
  input wire logic       mode_sys_offset,
  input wire logic       mode_sys_full_scale,
  input wire logic       mode_pseudo_cal,
  input wire logic       mode_background,
  input wire logic [2:0] operation_mode_field,
  input wire logic [2:0] active_mode
);
  wire  [5:0] strobes = {mode_background, mode_pseudo_cal, mode_sys_full_scale,
                         mode_sys_offset, mode_self_cal, mode_normal};
  logic       waking;
  logic [1:0] ends;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Wake tracking: set by the write that leaves sleep, cleared at the second conversion end.
  // Conversion ends inside power-up are assumed absent, which the bench honours.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waking <= 1'b0;
      ends   <= 2'h0;
    end else if (sleeping && mode_write && operation_mode_field != 3'h6) begin
      waking <= 1'b1;
      ends   <= 2'h0;
    end else if (waking && conv_cycle_end) begin
      waking <= (ends == 2'h0);
      ends   <= ends + 2'h1;
    end
  end
  sleep_entry_a: assert property (
    mode_write && operation_mode_field == 3'h6 && !sleeping && !waking |=> sleeping &&
    active_mode == 3'h6 && !analog_power_en && !digital_power_en && !serial_awake)
    else $error("sleep entry missed");
  sleep_hold_a: assert property (
    sleeping && !(mode_write && operation_mode_field != 3'h6) |=> sleeping)
    else $error("sleep ended early");
  enable_follow_a: assert property (
    $past(resetn, 3) |-> bias_enable == $past(bias_enable_in) &&
    reference_output_enable == $past(reference_output_enable_in))
    else $error("enable did not follow");
  select_wake_a: assert property (
    sleeping && cs_used && !chip_select_n |-> ##[1:3] serial_awake)
    else $error("select did not wake");
  edge_wake_a: assert property (
    sleeping && !cs_used && master_mode && $fell(sdio_in) && $past(sdio_in, 2) &&
    $past(sleeping, 2) |-> ##[1:3] serial_awake)
    else $error("data fall did not wake");
  instr_wake_a: assert property (
    sleeping && !cs_used && !master_mode && instr_strobe |-> ##[1:3] serial_awake)
    else $error("instruction did not wake");
  ready_held_a: assert property (waking |-> data_ready_n)
    else $error("data ready low during wake");
  mode_late_a: assert property (waking |-> strobes == 6'h00)
    else $error("mode applied early");
  run_decode_a: assert property (
    !sleeping && !waking && !$past(waking) && $past(resetn, 4) |-> strobes == 6'h01 << active_mode)
    else $error("mode decode wrong");
endmodule
bind asmc_sleep_ctrl asmc_sleep_ctrl_asserts asmc_sleep_ctrl_asserts_inst (.*);

// File: verification/asmc_host_model.sv
// Host model that writes the mode field and drives the serial wake signals.
`timescale 1ns/1ps
module asmc_host_model (
  input  wire logic       clock,
  input  wire logic       cs_used,
  output logic            mode_write,
  output logic [2:0]      operation_mode_field,
  output logic            chip_select_n,
  output logic            sdio_in,
  output logic            instr_strobe
);
  // ==========================================================
  // Idle levels; all changes land on falling edges, clear of the sampling edge.
  initial begin
    mode_write = 1'b0;
    operation_mode_field = 3'h0;
    chip_select_n = 1'b1;
    sdio_in = 1'b0;
    instr_strobe = 1'b0;
  end
  // A transaction opens with its instruction byte, then the mode write lands.
  task automatic write_mode(input logic [2:0] code);
    @(negedge clock) instr_strobe = 1'b1;
    chip_select_n = 1'b0;
    @(negedge clock) instr_strobe = 1'b0;
    mode_write = 1'b1;
    operation_mode_field = code;
    @(negedge clock) mode_write = 1'b0;
    chip_select_n = cs_used;
  endtask
  // Kinds: 0 select low, 1 data fall after two highs, 2 instruction, 3 too short a high.
  task automatic wake(input int kind);
    @(negedge clock);
    if (kind == 0) chip_select_n = 1'b0;
    else if (kind == 2) begin
      instr_strobe = 1'b1;
      @(negedge clock) instr_strobe = 1'b0;
    end else begin
      sdio_in = 1'b1;
      repeat (kind == 1 ? 2 : 1) @(negedge clock);
      sdio_in = 1'b0;
    end
  endtask
endmodule

// File: verification/asmc_sleep_ctrl_test.sv
// Self-checking bench for the converter sleep-mode controller.
`timescale 1ns/1ps
`include "asmc_defines.svh"
module asmc_sleep_ctrl_test;
  logic       clock = 1'b0, resetn = 1'b0, bias_enable_in = 1'b0, conv_cycle_end = 1'b0;
  logic       reference_output_enable_in = 1'b1, conv_data_ready = 1'b1;
  logic       cs_used = 1'b1, master_mode = 1'b0;
  logic       mode_write, chip_select_n, sdio_in, instr_strobe, sleeping, analog_power_en;
  logic       digital_power_en, bias_enable, reference_output_enable, serial_awake;
  logic       data_ready_n, mode_normal, mode_self_cal, mode_sys_offset, mode_sys_full_scale;
  logic       mode_pseudo_cal, mode_background;
  logic [2:0] operation_mode_field, active_mode;
  int         err_total = 0, comparisons = 0;
  wire  [5:0] strobes = {mode_background, mode_pseudo_cal, mode_sys_full_scale,
                         mode_sys_offset, mode_self_cal, mode_normal};
  asmc_sleep_ctrl asmc_sleep_ctrl_inst (.*);
  asmc_host_model asmc_host_model_inst (.*);
  always #10 clock = ~clock;
  // ==========================================================
  // Comparison, closing and conversion-end helpers.
  task automatic check(input string what, input logic [5:0] seen, input logic [5:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic end_conv;
    @(negedge clock) conv_cycle_end = 1'b1;
    @(negedge clock) conv_cycle_end = 1'b0;
  endtask
  // Values held while reset is asserted.
  task automatic reset_values;
    check("sleeping", sleeping, 0);
    check("power", {analog_power_en, digital_power_en}, 3);
    check("enables", {bias_enable, reference_output_enable}, 1);
    check("awake", serial_awake, 1);
    check("ready", data_ready_n, 1);
    check("mode", active_mode, 0);
    check("strobes", strobes, 0);
  endtask
  // A single-cycle high on the data line must not wake a master port.
  task automatic short_pulse_refused;
    asmc_host_model_inst.wake(3);
    repeat (4) @(negedge clock);
    check("glitch", serial_awake, 0);
  endtask
  // Sleep, toggle the enables, wake the port, then leave sleep into a new mode.
  task automatic sleep_and_wake(input logic [2:0] code, input int kind);
    @(negedge clock) cs_used = (kind == 0);
    master_mode = (kind == 1);
    asmc_host_model_inst.write_mode(`ASMC_MODE_SLEEP);
    check("sleeping", sleeping, 1);
    check("mode", active_mode, `ASMC_MODE_SLEEP);
    check("power", {analog_power_en, digital_power_en}, 0);
    check("awake", serial_awake, 0);
    bias_enable_in = ~bias_enable_in;
    reference_output_enable_in = ~reference_output_enable_in;
    repeat (2) @(negedge clock);
    check("enables", {bias_enable, reference_output_enable},
          {bias_enable_in, reference_output_enable_in});
    if (kind == 1) short_pulse_refused();
    asmc_host_model_inst.wake(kind);
    repeat (3) @(negedge clock);
    check("awake", serial_awake, 1);
    check("still", sleeping, 1);
    asmc_host_model_inst.write_mode(code);
    check("left", {sleeping, analog_power_en, digital_power_en}, 3);
    repeat (`ASMC_POWERUP_CYCLES + 2) @(negedge clock);
    end_conv();
    repeat (3) @(negedge clock);
    check("early", strobes, 0);
    check("held", data_ready_n, 1);
    end_conv();
    repeat (2) @(negedge clock);
    check("mode", active_mode, code);
    check("decode", strobes, 6'h01 << code);
    check("ready", data_ready_n, 0);
    // Once running, data-ready must mirror the converter again, both ways.
    conv_data_ready = 1'b0;
    repeat (2) @(negedge clock);
    check("ready", data_ready_n, 1);
    conv_data_ready = 1'b1;
  endtask
  // Main sequence: every mode code, wake kinds rotating through the three paths.
  initial begin
    repeat (4) @(negedge clock);
    reset_values();
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    for (int c = 0; c < 6; c++) sleep_and_wake(c[2:0], c % 3);
    tally_and_finish();
  end
  // Watchdog sized well past the roughly 280 cycles the sequence needs.
  initial begin
    #100us;
    err_total++;
    tally_and_finish();
  end
endmodule
